// >>> logic/cir_cfg.svh
// constants for the cascaded interrupt routing block
`ifndef CIR_CFG_SVH
`define CIR_CFG_SVH
`define CIR_NUM_IN      8
`define CIR_NUM_SRC     17
`define CIR_IDX_W       3
`define CIR_SEL_W       5
`define CIR_VEC_W       8
`define CIR_SRC_BUS0    9
`define CIR_SEL_NONE    5'h1F
`define CIR_VEC_HI      5'h00
`endif

// >>> logic/cir_pkg.sv
// types for the cascaded interrupt routing block
package cir_pkg;
  typedef enum logic [1:0] {
    cir_idle,
    cir_wait_ack2,
    cir_release
  } cir_state_t;
endpackage

// >>> logic/cir_top.sv
// interrupt routing, priority resolution and cascade control toward the cpu
`timescale 1ns/1ps
`include "cir_cfg.svh"
module cir_top #(
  parameter int NUM_IN = `CIR_NUM_IN
) (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_sys_rst,
  input  wire logic [8:0]              i_onboard_src,
  input  wire logic [NUM_IN-1:0]       i_bus_interrupt_lines_n,
  input  wire logic [NUM_IN*5-1:0]     i_route_sel,
  input  wire logic [NUM_IN-1:0]       i_slave_vectored_line,
  input  wire logic [NUM_IN-1:0]       i_mask,
  input  wire logic                    i_inta_n,
  input  wire logic                    i_parallel_port_unit_bit,
  input  wire logic [`CIR_IDX_W-1:0]   i_out_line_sel,
  output logic                         o_cpu_maskable_request,
  output logic [`CIR_VEC_W-1:0]        o_vector,
  output logic                         o_vector_oe,
  output logic [`CIR_IDX_W-1:0]        o_cascade_code,
  output logic                         o_cascade_oe,
  output logic [NUM_IN-1:0]            o_bus_int_out,
  output logic [NUM_IN-1:0]            o_bus_int_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second, nothing else reads it
  logic [8:0]        src_s1;
  logic [8:0]        src_s2;
  logic [NUM_IN-1:0] bus_s1;
  logic [NUM_IN-1:0] bus_s2;
  logic [1:0]        ack_s;
  logic              ack_d;
  logic              pp_s1;
  logic              pp_s2;

  // on-board sources reset to idle low so no request shows while the pipe refills
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      src_s1 <= '0;
      src_s2 <= '0;
    end else begin
      src_s1 <= i_onboard_src;
      src_s2 <= src_s1;
    end
  end

  // bus lines are active low, so their idle level after reset is all ones
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bus_s1 <= '1;
      bus_s2 <= '1;
    end else begin
      bus_s1 <= i_bus_interrupt_lines_n;
      bus_s2 <= bus_s1;
    end
  end

  // acknowledge pipe and its delayed copy start high, the pin's idle level,
  // so the release of reset never shows a false falling edge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack_s <= '1;
      ack_d <= 1'b1;
    end else begin
      ack_s <= {ack_s[0], i_inta_n};
      ack_d <= ack_s[1];
    end
  end

  // parallel port bit that asks for the outward bus line
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pp_s1 <= 1'b0;
      pp_s2 <= 1'b0;
    end else begin
      pp_s1 <= i_parallel_port_unit_bit;
      pp_s2 <= pp_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // source pool: nine on-board sources then eight bus lines made active high
  // more than 31 sources would also need a wider select field per input
  logic [`CIR_NUM_SRC-1:0] pool;
  assign pool = {~bus_s2, src_s2};

  // fixed select per input; out-of-range select leaves the input idle
  // selects are straps and are not synchronised: change them only while idle
  logic [NUM_IN-1:0] req;
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_route
      logic [`CIR_SEL_W-1:0] sel;
      assign sel = i_route_sel[g*`CIR_SEL_W +: `CIR_SEL_W];
      assign req[g] = (sel < `CIR_SEL_W'(`CIR_NUM_SRC)) ? pool[sel] : 1'b0;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // fixed priority, input zero highest; the winner is the lowest live unmasked input
  // trade-off: no rotation, so a busy input zero can starve the lower inputs
  logic [NUM_IN-1:0]     live;
  logic                  any_live;
  logic [`CIR_IDX_W-1:0] win;
  assign live = req & ~i_mask;
  always_comb begin
    any_live = 1'b0;
    win      = '0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (live[i]) begin
        any_live = 1'b1;
        win      = `CIR_IDX_W'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge sequencer: falling ack edges count first and second cycles
  // edges come from the second sync stage only, since the pin is asynchronous;
  // a low or high phase shorter than one clock may be lost
  cir_pkg::cir_state_t   state;
  logic [`CIR_IDX_W-1:0] cur;
  logic                  cur_slave;
  logic                  ack_fall;
  logic                  ack_rise;
  assign ack_fall = ack_d & ~ack_s[1];
  assign ack_rise = ~ack_d & ack_s[1];
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state     <= cir_pkg::cir_idle;
      cur       <= '0;
      cur_slave <= 1'b0;
    end else begin
      case (state)
        cir_pkg::cir_idle: begin
          // an acknowledge with nothing live is ignored and the sequencer stays idle
          if (ack_fall && any_live) begin
            cur       <= win; // latch winner on first acknowledge
            cur_slave <= i_slave_vectored_line[win];
            state     <= cir_pkg::cir_wait_ack2;
          end
        end
        cir_pkg::cir_wait_ack2: begin
          if (ack_fall) begin
            state <= cir_pkg::cir_release;
          end
        end
        cir_pkg::cir_release: begin
          // wait for the rise so a long second low phase is not taken twice;
          // a third acknowledge before this point has no effect
          if (ack_rise) begin
            state <= cir_pkg::cir_idle;
          end
        end
        default: state <= cir_pkg::cir_idle;
      endcase
    end
  end

  // request to cpu held off during an acknowledge so only one is presented;
  // it drops on the edge that takes the first acknowledge, not one edge later
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_cpu_maskable_request <= 1'b0;
    end else begin
      o_cpu_maskable_request <= any_live && (state == cir_pkg::cir_idle) && !ack_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cascade code stands from first acknowledge until the sequence ends
  // the code is loaded for local inputs too, but only enabled for slave inputs
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_cascade_code <= '0;
      o_cascade_oe   <= 1'b0;
    end else if (state == cir_pkg::cir_idle && ack_fall && any_live) begin
      o_cascade_code <= win;
      o_cascade_oe   <= i_slave_vectored_line[win];
    end else if (state == cir_pkg::cir_release && ack_rise) begin
      o_cascade_oe   <= 1'b0;
    end
  end

  // local vector driven only during the second acknowledge; slave lines never drive it
  // upper bits stay zero; the cpu scales the byte into its table itself
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_vector    <= '0;
      o_vector_oe <= 1'b0;
    end else if (state == cir_pkg::cir_wait_ack2 && ack_fall) begin
      o_vector    <= {`CIR_VEC_HI, cur};
      o_vector_oe <= ~cur_slave;
    end else if (state == cir_pkg::cir_release && ack_rise) begin
      o_vector_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outward bus line: open drain, pulled low while the port bit is high
  // the line is never driven high; an external pull-up restores it
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_bus_int_oe <= '0;
    end else begin
      o_bus_int_oe <= NUM_IN'(pp_s2) << i_out_line_sel;
    end
  end
  assign o_bus_int_out = '0; // drives low only
endmodule

// >>> verif/cir_properties.sv
// port assertions for the interrupt routing block
`timescale 1ns/1ps
module cir_properties #(
  parameter int NUM_IN = 8
) (
  input wire logic              i_clk_sys,
  input wire logic              i_sys_rst,
  input wire logic              i_inta_n,
  input wire logic [NUM_IN-1:0] i_slave_vectored_line,
  input wire logic [2:0]        i_out_line_sel,
  input wire logic              o_cpu_maskable_request,
  input wire logic [7:0]        o_vector,
  input wire logic              o_vector_oe,
  input wire logic [2:0]        o_cascade_code,
  input wire logic              o_cascade_oe,
  input wire logic [NUM_IN-1:0] o_bus_int_out,
  input wire logic [NUM_IN-1:0] o_bus_int_oe
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  chk_vec_byte: assert property (o_vector_oe |-> o_vector == {5'h00, o_cascade_code})
    else $error("vector byte wrong");
  chk_local_only: assert property (o_vector_oe |-> !i_slave_vectored_line[o_cascade_code])
    else $error("vector driven for slave input");
  chk_casc_slave: assert property (o_cascade_oe |-> i_slave_vectored_line[o_cascade_code])
    else $error("cascade code for local input");
  chk_one_answer: assert property (!(o_vector_oe && o_cascade_oe))
    else $error("two answers at once");
  chk_req_quiet: assert property ((o_vector_oe || o_cascade_oe) |-> !o_cpu_maskable_request)
    else $error("request during acknowledge");
  chk_vec_ack: assert property ($rose(o_vector_oe) |-> !$past(i_inta_n, 2))
    else $error("vector without acknowledge");
  chk_vec_stands: assert property ($fell(o_vector_oe) |-> $past(i_inta_n, 2))
    else $error("vector dropped early");
  chk_casc_ack: assert property ($rose(o_cascade_oe) |-> !$past(i_inta_n, 2))
    else $error("cascade code without acknowledge");
  chk_line_drive: assert property (o_bus_int_out == '0 &&
    (o_bus_int_oe == '0 || o_bus_int_oe == (8'h01 << i_out_line_sel)))
    else $error("outward line wrong");
endmodule
bind cir_top cir_properties #(.NUM_IN(NUM_IN)) u_cir_properties (.*);

// >>> verif/cir_cpu_model.sv
// cpu acknowledge sequencer and cascaded slave controller model
`timescale 1ns/1ps
module cir_cpu_model #(
  parameter logic [2:0] SLV_IN = 3'h2
) (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_vector,
  input  wire logic       i_vector_oe,
  input  wire logic [2:0] i_cascade_code,
  input  wire logic       i_cascade_oe,
  output logic            o_inta_n
);
  logic [7:0] last = 8'h00;
  initial o_inta_n = 1'b1;
  // two acknowledges; a released bus reads as the inverse of the last byte
  task automatic ack(output logic [7:0] b);
    repeat (2) begin
      @(negedge i_clk) o_inta_n = 1'b0;
      repeat (4) @(negedge i_clk);
      b = i_vector_oe ? i_vector : i_cascade_oe ? {2'b00, i_cascade_code, SLV_IN} : ~last;
      o_inta_n = 1'b1;
      repeat (4) @(negedge i_clk);
    end
    last = b;
  endtask
endmodule

// >>> verif/cir_top_tb_top.sv
// self-checking bench for the interrupt routing block
`timescale 1ns/1ps
module cir_top_tb_top;
  logic clk = 1'b0, rst = 1'b1, pbit = 1'b0, inta_n, req, voe, coe;
  logic [8:0] src = 9'h000;
  logic [7:0] busn = 8'hFF, slv = 8'h00, msk = 8'h00, vec, boe, bout, rd;
  logic [39:0] route = {8{5'h1F}};
  logic [2:0] osel = 3'h0, code;
  int err_total = 0, n_tests = 0, cyc = 0;
  cir_top u_cir_top (.i_clk_sys(clk), .i_sys_rst(rst), .i_onboard_src(src),
    .i_bus_interrupt_lines_n(busn), .i_route_sel(route), .i_slave_vectored_line(slv),
    .i_mask(msk), .i_inta_n(inta_n), .i_parallel_port_unit_bit(pbit), .i_out_line_sel(osel),
    .o_cpu_maskable_request(req), .o_vector(vec), .o_vector_oe(voe), .o_cascade_code(code),
    .o_cascade_oe(coe), .o_bus_int_out(bout), .o_bus_int_oe(boe));
  cir_cpu_model u_cir_cpu_model (.i_clk(clk), .i_vector(vec), .i_vector_oe(voe),
    .i_cascade_code(code), .i_cascade_oe(coe), .o_inta_n(inta_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      err_total++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // raise sources, wait for the request (bounded), acknowledge, compare the byte
  task automatic irq(input logic [8:0] s, input logic [7:0] b, input logic [7:0] exp);
    @(negedge clk);
    src = s;
    busn = b;
    for (int i = 0; i < 20 && req !== 1'b1; i++) @(negedge clk);
    u_cir_cpu_model.ack(rd);
    check(rd === exp, "identifier byte");
    src = 9'h000;
    busn = 8'hFF;
    repeat (8) @(negedge clk);
  endtask
  // every on-board source routed to input 7, answered locally
  task automatic t_onboard;
    for (int s = 0; s < 9; s++) begin
      route[35+:5] = 5'(s);
      irq(9'(1 << s), 8'hFF, 8'h07);
    end
  endtask
  // local input 1 beats slave input 3; then slave alone; masked input stays silent
  task automatic t_mixed;
    route = {{4{5'h1F}}, 5'h09, 5'h1F, 5'h00, 5'h1F};
    slv = 8'h08;
    irq(9'h001, 8'hFE, 8'h01);
    irq(9'h000, 8'hFE, 8'h1A);
    msk = 8'h02;
    src = 9'h001;
    repeat (10) @(negedge clk);
    check(req === 1'b0, "masked request");
    src = 9'h000;
    repeat (4) @(negedge clk); // let the synchronised source drain before unmasking
    msk = 8'h00;
  endtask
  // eight slaves on eight bus lines, each answering for its slave input 2
  task automatic t_bus;
    slv = 8'hFF;
    for (int g = 0; g < 8; g++) route[g*5+:5] = 5'(9 + g);
    for (int g = 0; g < 8; g++) irq(9'h000, ~(8'h01 << g), {2'b00, 3'(g), 3'h2});
  endtask
  // the port bit pulls the selected bus line low
  task automatic t_out;
    for (int o = 0; o < 8; o++) begin
      osel = 3'(o);
      pbit = 1'b1;
      repeat (6) @(negedge clk);
      check(boe === (8'h01 << o), "outward line");
      check(bout === 8'h00, "outward level");
      pbit = 1'b0;
      repeat (6) @(negedge clk);
      check(boe === 8'h00, "outward release");
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // clock; the cycle ceiling cuts a hang short
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_onboard();
    t_mixed();
    t_bus();
    t_out();
    summarize();
  end
endmodule
